// >>> design/stl_pkg.sv
// package for the serial temperature-limit interface block
// assumes one 100 MHz clock; serial pins sampled and edge-detected inside
// Behaviour
// - alert on temperature above the upper limit
// - alert on temperature below the lower limit
// - upper limit: 16-bit signed, read/write, resets to 0x2000
// - lower limit: 16-bit signed, read/write, resets to 0x0500
// - hysteresis: low four bits, resets to 0101, upper bits zero
// - input sampled on rising clock, output changed on falling clock
// - command bit six: one reads, zero writes
// - command bits five to three address one register
// - bit two with temperature read repeats it every 16 clocks
// - write data of 8 or 16 bits captured on rising edges
// - read shifts register out from first falling edge after command
// - select falling edge drives the data output low; free-running clock tolerated
// - works with select tied low, three-wire
// - 32 clocks of ones reset interface and registers
// - alert outputs are open drain: pull active or release
// - hysteresis subtracted from upper, added to lower for clearing
// - comparator mode clears alert past limit with hysteresis
// - interrupt mode clears alert on any read, re-arms on new crossing
package stl_pkg;
   // ---------------------------------------------------------------
   // register addresses
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_STATUS = 3'h0;
   localparam logic [2:0] ADDR_TEMP = 3'h2;
   localparam logic [2:0] ADDR_ID = 3'h3;
   localparam logic [2:0] ADDR_CRIT = 3'h4;
   localparam logic [2:0] ADDR_HYST = 3'h5;
   localparam logic [2:0] ADDR_HIGH = 3'h6;
   localparam logic [2:0] ADDR_LOW = 3'h7;
   // ---------------------------------------------------------------
   // reset values and field positions
   // ---------------------------------------------------------------
   localparam logic [15:0] HIGH_RESET = 16'h2000;
   localparam logic [15:0] LOW_RESET = 16'h0500;
   localparam logic [15:0] CRIT_RESET = 16'h4980;
   localparam logic [7:0] HYST_RESET = 8'h05;
   localparam int HYST_W = 4;
   localparam int DEG_LSB = 7; // one degree = bit 7 of a 16-bit value
   localparam int CMD_TOP = 7;
   localparam int CMD_DIR = 6;
   localparam int CMD_ADDR_HI = 5;
   localparam int CMD_ADDR_LO = 3;
   localparam int CMD_REPEAT = 2;
   localparam logic [5:0] ONES_RESET_COUNT = 6'h20;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   // arbitrary neutral identity value
   localparam logic [7:0] ID_VALUE = 8'h5A;
   // ---------------------------------------------------------------
   // transaction states and carried word
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_CMD = 4'b0001,
      ST_WRITE = 4'b0010,
      ST_READ = 4'b0100,
      ST_DONE = 4'b1000
   } stl_state_t;
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] data;
   } stl_wr_t;
endpackage

// >>> design/stl_fifo.sv
// small valid/ready fifo for register write words
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module stl_fifo #(
   parameter int WIDTH = 19,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   wire empty = (wr_ptr == rd_ptr);
   wire push = in_valid_i && !full;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = !full;
   // read data held in a register so the output stays flop-driven
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else begin
         if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (!out_valid_o || pop) begin
            out_valid_o <= !empty;
            if (!empty) begin
               out_data_o <= mem[rd_ptr[AW-1:0]];
               rd_ptr <= rd_ptr + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// >>> design/stl_top.sv
// serial slave with limit registers and open-drain alert outputs
// assumes serial pins are asynchronous; temperature comes from a converter
`timescale 1ns/1ns
`default_nettype none
module stl_top #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic din_i,
   output logic dout_o,
   output logic dout_oe_o,
   input wire logic [15:0] temp_i,
   input wire logic temp_valid_i,
   input wire logic cmp_mode_i,
   input wire logic alert_pol_i,
   output logic limit_alert_out_o,
   output logic limit_alert_oe_o,
   output logic critical_alert_out_o,
   output logic critical_alert_oe_o
);
   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   logic [1:0] sclk_s;
   logic [1:0] cs_s;
   logic [1:0] din_s;
   logic sclk_d;
   logic cs_d;
   // first stage is read only by the second stage
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sclk_s <= 2'b11;
         cs_s <= 2'b11;
         din_s <= 2'b00;
         sclk_d <= 1'b1;
         cs_d <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[0], sclk_i};
         cs_s <= {cs_s[0], cs_n_i};
         din_s <= {din_s[0], din_i};
         sclk_d <= sclk_s[1];
         cs_d <= cs_s[1];
      end
   end
   wire sclk_rise = sclk_s[1] && !sclk_d;
   wire sclk_fall = !sclk_s[1] && sclk_d;
   wire cs_fall = !cs_s[1] && cs_d;
   wire cs_high = cs_s[1];
   wire din_bit = din_s[1];

   // ---------------------------------------------------------------
   // registers and transaction state
   // ---------------------------------------------------------------
   stl_pkg::stl_state_t state;
   stl_pkg::stl_state_t next_state;
   logic [15:0] upper_temp_limit;
   logic [15:0] lower_temp_limit;
   logic [15:0] critical_limit;
   logic [7:0] hysteresis_setting;
   logic [15:0] temp_value;
   logic [15:0] shift_in;
   logic [15:0] shift_out;
   logic [4:0] bit_cnt;
   logic [7:0] cmd;
   logic [5:0] ones_cnt;
   logic limit_alert;
   logic crit_alert;
   logic high_flag;
   logic low_flag;

   // helper: byte-wide registers
   function automatic logic is_byte(input logic [2:0] a);
      return (a == stl_pkg::ADDR_HYST) || (a == stl_pkg::ADDR_ID)
         || (a == stl_pkg::ADDR_STATUS);
   endfunction
   function automatic logic [15:0] read_mux(input logic [2:0] a);
      case (a)
         stl_pkg::ADDR_STATUS: read_mux = {limit_alert, crit_alert, high_flag,
            low_flag, 12'h000};
         stl_pkg::ADDR_TEMP: read_mux = temp_value;
         stl_pkg::ADDR_ID: read_mux = {stl_pkg::ID_VALUE, 8'h00};
         stl_pkg::ADDR_CRIT: read_mux = critical_limit;
         stl_pkg::ADDR_HYST: read_mux = {hysteresis_setting, 8'h00};
         stl_pkg::ADDR_HIGH: read_mux = upper_temp_limit;
         stl_pkg::ADDR_LOW: read_mux = lower_temp_limit;
         default: read_mux = 16'h0000;
      endcase
   endfunction

   // command fields, taken from the byte as it completes
   wire [7:0] cmd_next = {shift_in[6:0], din_bit};
   wire cmd_direction_bit = cmd_next[stl_pkg::CMD_DIR];
   wire [2:0] cmd_reg_addr =
      cmd_next[stl_pkg::CMD_ADDR_HI:stl_pkg::CMD_ADDR_LO];
   wire cmd_repeat_read_bit = cmd_next[stl_pkg::CMD_REPEAT];
   wire [2:0] cur_addr = cmd[stl_pkg::CMD_ADDR_HI:stl_pkg::CMD_ADDR_LO];
   wire [4:0] cur_len = is_byte(cur_addr) ? stl_pkg::BYTE_BITS
      : stl_pkg::WORD_BITS;
   wire cmd_done = (state == stl_pkg::ST_CMD) && sclk_rise
      && (bit_cnt == 5'd7);
   wire wr_done = (state == stl_pkg::ST_WRITE) && sclk_rise
      && (bit_cnt == cur_len - 5'd1);
   wire cont_read = cmd[stl_pkg::CMD_REPEAT]
      && (cur_addr == stl_pkg::ADDR_TEMP);
   wire rd_word_end = (state == stl_pkg::ST_READ) && sclk_rise
      && (bit_cnt == cur_len - 5'd1);
   wire ones_reset = (ones_cnt == stl_pkg::ONES_RESET_COUNT);
   wire read_start = cmd_done && cmd_direction_bit;

   // ---------------------------------------------------------------
   // write fifo: decouples the serial capture from register update
   // ---------------------------------------------------------------
   stl_pkg::stl_wr_t wr_in;
   stl_pkg::stl_wr_t wr_out;
   logic wr_out_valid;
   wire [15:0] wr_word = is_byte(cur_addr) ? {8'h00, cmd_next}
      : {shift_in[14:0], din_bit};
   assign wr_in.addr = cur_addr;
   assign wr_in.data = wr_word;
   stl_fifo #(
      .WIDTH($bits(stl_pkg::stl_wr_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i || ones_reset),
      .in_valid_i(wr_done),
      .in_ready_o(),
      .in_data_i(wr_in),
      .out_valid_o(wr_out_valid),
      .out_ready_i(1'b1),
      .out_data_o(wr_out)
   );

   // next state of the transaction engine
   always_comb begin
      next_state = state;
      case (state)
         stl_pkg::ST_CMD: if (cmd_done) begin
            next_state = cmd_direction_bit ? stl_pkg::ST_READ
               : stl_pkg::ST_WRITE;
         end
         stl_pkg::ST_WRITE: if (wr_done) begin
            next_state = stl_pkg::ST_DONE;
         end
         stl_pkg::ST_READ: if (rd_word_end && !cont_read) begin
            next_state = stl_pkg::ST_DONE;
         end
         stl_pkg::ST_DONE: next_state = stl_pkg::ST_CMD;
         default: next_state = stl_pkg::ST_CMD;
      endcase
      if (cs_fall) begin
         next_state = stl_pkg::ST_CMD;
      end
   end
   // ones counter: counts rising clocks with din high, even mid-frame
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || ones_reset) begin
         ones_cnt <= '0;
      end else if (sclk_rise) begin
         ones_cnt <= din_bit ? ones_cnt + 6'd1 : 6'd0;
      end
   end
   // serial shift engine; select high drops any partial byte
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || ones_reset || (cs_high && !cs_fall)) begin
         state <= stl_pkg::ST_CMD;
         bit_cnt <= '0;
         shift_in <= '0;
         cmd <= '0;
      end else begin
         state <= next_state;
         if (cs_fall) begin
            bit_cnt <= '0;
         end else if (sclk_rise) begin
            shift_in <= {shift_in[14:0], din_bit};
            if (cmd_done) begin
               cmd <= cmd_next;
               bit_cnt <= '0;
            end else if (wr_done || rd_word_end) begin
               bit_cnt <= '0;
            end else begin
               bit_cnt <= bit_cnt + 5'd1;
            end
         end
      end
   end
   // output shifter: loaded at command end, moves on falling edges
   logic load_pend;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || ones_reset) begin
         shift_out <= '0;
         dout_o <= 1'b0;
         dout_oe_o <= 1'b0;
         load_pend <= 1'b0;
      end else begin
         dout_oe_o <= !cs_high;
         if (cs_fall) begin
            dout_o <= 1'b0;
         end
         if (read_start || (rd_word_end && cont_read)) begin
            shift_out <= read_mux(read_start ? cmd_reg_addr : cur_addr);
            load_pend <= 1'b1;
         end else if (sclk_fall && state == stl_pkg::ST_READ) begin
            dout_o <= load_pend ? shift_out[15] : shift_out[14];
            shift_out <= load_pend ? shift_out : {shift_out[14:0], 1'b0};
            load_pend <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // register file and limit comparison
   // ---------------------------------------------------------------
   wire signed [16:0] t_s = {temp_value[15], temp_value};
   wire signed [16:0] hi_s = {upper_temp_limit[15], upper_temp_limit};
   wire signed [16:0] lo_s = {lower_temp_limit[15], lower_temp_limit};
   wire signed [16:0] cr_s = {critical_limit[15], critical_limit};
   wire signed [16:0] hy_s =
      17'(hysteresis_setting[stl_pkg::HYST_W-1:0]) << stl_pkg::DEG_LSB;
   wire over = t_s > hi_s;
   wire under = t_s < lo_s;
   wire over_clr = t_s < (hi_s - hy_s);
   wire under_clr = t_s > (lo_s + hy_s);
   wire crit = t_s > cr_s;
   wire crit_clr = t_s < (cr_s - hy_s);
   wire any_read = read_start;
   // writes drain from the fifo into the addressed register
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || ones_reset) begin
         upper_temp_limit <= stl_pkg::HIGH_RESET;
         lower_temp_limit <= stl_pkg::LOW_RESET;
         hysteresis_setting <= stl_pkg::HYST_RESET;
         critical_limit <= stl_pkg::CRIT_RESET;
         temp_value <= '0;
      end else begin
         if (temp_valid_i) begin
            temp_value <= temp_i;
         end
         if (wr_out_valid) begin
            case (wr_out.addr)
               stl_pkg::ADDR_HIGH: upper_temp_limit <= wr_out.data;
               stl_pkg::ADDR_LOW: lower_temp_limit <= wr_out.data;
               stl_pkg::ADDR_CRIT: critical_limit <= wr_out.data;
               stl_pkg::ADDR_HYST: hysteresis_setting <=
                  {4'h0, wr_out.data[stl_pkg::HYST_W-1:0]};
               default: ;
            endcase
         end
      end
   end
   // alert state: comparator clears with hysteresis, interrupt on read
   always_ff @(posedge ref_clk_i) begin
      if (reset_i || ones_reset) begin
         limit_alert <= 1'b0;
         crit_alert <= 1'b0;
         high_flag <= 1'b0;
         low_flag <= 1'b0;
      end else begin
         high_flag <= over && !high_flag ? 1'b1 : (over_clr ? 1'b0 : high_flag);
         low_flag <= under && !low_flag ? 1'b1 : (under_clr ? 1'b0 : low_flag);
         if (cmp_mode_i) begin
            if (over || under) begin
               limit_alert <= 1'b1;
            end else if ((over_clr && !under) || (under_clr && !over)) begin
               limit_alert <= (!over_clr && high_flag)
                  || (!under_clr && low_flag);
            end
         end else begin
            // a fresh crossing wins over a read in the same cycle
            if ((over && !high_flag) || (under && !low_flag)) begin
               limit_alert <= 1'b1;
            end else if (any_read) begin
               limit_alert <= 1'b0;
            end
         end
         crit_alert <= crit ? 1'b1 : (crit_clr ? 1'b0 : crit_alert);
      end
   end
   // open drain: drive active level only while alerted
   assign limit_alert_out_o = alert_pol_i;
   assign limit_alert_oe_o = limit_alert;
   assign critical_alert_out_o = 1'b0;
   assign critical_alert_oe_o = crit_alert;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_reg_reset;
      @(posedge ref_clk_i) reset_i |=> upper_temp_limit == 16'h2000
         && lower_temp_limit == 16'h0500 && hysteresis_setting == 8'h05;
   endproperty
   a_reg_reset: assert property (p_reg_reset) else $error("bad reset");
   property p_over;
      @(posedge ref_clk_i) disable iff (reset_i)
         (over && (cmp_mode_i || !high_flag) && !ones_reset) |=> limit_alert;
   endproperty
   a_over: assert property (p_over) else $error("no over alert");
   property p_under;
      @(posedge ref_clk_i) disable iff (reset_i)
         (under && (cmp_mode_i || !low_flag) && !ones_reset) |=> limit_alert;
   endproperty
   a_under: assert property (p_under) else $error("no under alert");
   property p_ones;
      @(posedge ref_clk_i) disable iff (reset_i)
         ones_reset |=> upper_temp_limit == 16'h2000 && state == stl_pkg::ST_CMD;
   endproperty
   a_ones: assert property (p_ones) else $error("no ones reset");
   property p_od;
      @(posedge ref_clk_i) disable iff (reset_i)
         (crit && !ones_reset) |=> critical_alert_oe_o && !critical_alert_out_o;
   endproperty
   a_od: assert property (p_od) else $error("open drain");
   property p_int_clr;
      @(posedge ref_clk_i) disable iff (reset_i)
         (!cmp_mode_i && any_read && !over && !under && !ones_reset)
         |=> !limit_alert;
   endproperty
   a_int_clr: assert property (p_int_clr) else $error("no read clear");
   property p_hyst;
      @(posedge ref_clk_i) disable iff (reset_i)
         hysteresis_setting[7:4] == 4'h0;
   endproperty
   a_hyst: assert property (p_hyst) else $error("hyst high bits");
   property p_cs_abort;
      @(posedge ref_clk_i) disable iff (reset_i)
         (cs_high && !cs_fall) |=> bit_cnt == 5'd0;
   endproperty
   a_cs_abort: assert property (p_cs_abort) else $error("no abort");
   c_write: cover property (@(posedge ref_clk_i) wr_done);
   c_read: cover property (@(posedge ref_clk_i) read_start);
   c_cont: cover property (@(posedge ref_clk_i) rd_word_end && cont_read);
endmodule
`default_nettype wire

// >>> testbench/stl_master.sv
// serial master model for the temperature-limit block
// assumes a 100 MHz bench clock; sclk runs at 80 ns only inside frames
`timescale 1ns/1ns
`default_nettype none
module stl_master (
   input wire logic ref_clk_i,
   output logic sclk_o,
   output logic cs_n_o,
   output logic din_o,
   input wire logic dout_i
);
   // ----------------------------------------
   // idle levels and frame task
   // ----------------------------------------
   // select stays low between frames when set, as in three-wire use
   logic tied_low = 1'b0;
   // clock idles high between frames
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o = 1'b0;
   end
   // one frame of n bits, msb first; half period is four bench clocks
   task automatic xfer(input logic [39:0] tx, input int n,
                       output logic [39:0] rx);
      rx = '0;
      @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o <= 1'b0;
         din_o <= tx[i];
         repeat (4) @(posedge ref_clk_i);
         sclk_o <= 1'b1;
         // sample late: the output settles a few clocks after the fall
         repeat (2) @(posedge ref_clk_i);
         rx[i] = dout_i;
         repeat (2) @(posedge ref_clk_i);
      end
      cs_n_o <= !tied_low;
      din_o <= ~din_o; // released line shows no stale value
      repeat (8) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// >>> testbench/spi_temp_limit_interface_test.sv
// self-checking bench for the serial temperature-limit block
// assumes stl_pkg, stl_top and the stl_master model are compiled first
`timescale 1ns/1ns
`default_nettype none
module spi_temp_limit_interface_test;
   // ----------------------------------------
   // signals, instances and helpers
   // ----------------------------------------
   typedef struct packed {
      logic [2:0] a;
      logic wr;
      logic [15:0] d;
      logic [15:0] e;
   } stl_row_t;
   logic ref_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [15:0] temp_i = 16'h0000;
   logic temp_valid_i = 1'b0;
   logic cmp_mode_i = 1'b1;
   logic alert_pol_i = 1'b0;
   wire sclk, cs_n, din, dout, dout_oe, lim_out, lim_oe, crit_out, crit_oe;
   // released lines: output floats, alert pin pulled up
   wire dout_line = dout_oe ? dout : 1'bz;
   wire alert_line = lim_oe ? lim_out : 1'b1;
   int err_total = 0;
   int num_checks = 0;
   stl_row_t rows [7] = '{
      '{stl_pkg::ADDR_HYST, 1'b0, 16'h0000, 16'h0005},
      '{stl_pkg::ADDR_HIGH, 1'b0, 16'h0000, 16'h2000},
      '{stl_pkg::ADDR_LOW, 1'b0, 16'h0000, 16'h0500},
      '{stl_pkg::ADDR_ID, 1'b0, 16'h0000, {8'h00, stl_pkg::ID_VALUE}},
      '{stl_pkg::ADDR_HYST, 1'b1, 16'h000A, 16'h000A},
      '{stl_pkg::ADDR_HIGH, 1'b1, 16'h3FFF, 16'h3FFF},
      '{stl_pkg::ADDR_LOW, 1'b1, 16'h8001, 16'h8001}};
   // temperature, expected limit alert, expected critical alert
   logic [17:0] trows [8] = '{{16'h2080, 2'b10}, {16'h1E00, 2'b10},
      {16'h1D00, 2'b00}, {16'h0400, 2'b10}, {16'h0700, 2'b10},
      {16'h0800, 2'b00}, {16'h4A00, 2'b11}, {16'h0800, 2'b00}};

   always #5 ref_clk_i = ~ref_clk_i;

   stl_master master (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .cs_n_o(cs_n),
      .din_o(din), .dout_i(dout_line));

   stl_top #(.FIFO_DEPTH(8)) dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
      .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din), .dout_o(dout),
      .dout_oe_o(dout_oe), .temp_i(temp_i), .temp_valid_i(temp_valid_i),
      .cmp_mode_i(cmp_mode_i), .alert_pol_i(alert_pol_i),
      .limit_alert_out_o(lim_out), .limit_alert_oe_o(lim_oe),
      .critical_alert_out_o(crit_out), .critical_alert_oe_o(crit_oe));

   // compare and count; unknowns never match
   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one register access; 8-bit width for hysteresis, id and status
   task automatic rw(input logic [2:0] a, input logic wr,
                     input logic [15:0] d, output logic [15:0] q);
      int w;
      logic [39:0] rx;
      logic [7:0] cmd;
      w = (a == stl_pkg::ADDR_HYST || a == stl_pkg::ADDR_ID
         || a == stl_pkg::ADDR_STATUS) ? 8 : 16;
      cmd = {1'b0, ~wr, a, 3'b000};
      master.xfer(({32'h0000_0000, cmd} << w) | 40'(d), 8 + w, rx);
      q = (w == 8) ? {8'h00, rx[7:0]} : rx[15:0];
   endtask
   // load a converter result and let the compare settle
   task automatic set_temp(input logic [15:0] t);
      @(posedge ref_clk_i);
      temp_i <= t;
      temp_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      temp_valid_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
   endtask
   // single exit point for both the tests and the watchdog
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      logic [15:0] q;
      logic [39:0] rx;
      repeat (5) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      foreach (rows[i]) begin
         if (rows[i].wr) rw(rows[i].a, 1'b1, rows[i].d, q);
         rw(rows[i].a, 1'b0, 16'h0000, q);
         chk("register", q, rows[i].e);
      end
      $display("test register table done");
      // write cut short after its first data byte must not land
      master.xfer({24'h00_0000, 8'h30, 8'hAA}, 16, rx);
      rw(stl_pkg::ADDR_HIGH, 1'b0, 16'h0000, q);
      chk("abandoned write", q, 16'h3FFF);
      chk("dout released", {15'h0000, dout_oe}, 16'h0000);
      $display("test abandon done");
      // a run of ones restores every register; long quiet time after
      master.xfer(40'hFF_FFFF_FFFF, 32, rx);
      repeat (50000) @(posedge ref_clk_i);
      for (int i = 0; i < 3; i++) begin
         rw(rows[i].a, 1'b0, 16'h0000, q);
         chk("after ones", q, rows[i].e);
      end
      $display("test ones reset done");
      // comparator mode, active-low pin
      foreach (trows[i]) begin
         set_temp(trows[i][17:2]);
         chk("alerts", {13'h0000, lim_oe, crit_oe, alert_line},
             {13'h0000, trows[i][1:0], ~trows[i][1]});
      end
      chk("crit drive", {15'h0000, crit_out}, 16'h0000);
      $display("test comparator done");
      // interrupt mode, active-high pin; a read clears the alert
      cmp_mode_i <= 1'b0;
      alert_pol_i <= 1'b1;
      rw(stl_pkg::ADDR_HYST, 1'b0, 16'h0000, q);
      set_temp(16'h2100);
      chk("int set", {14'h0000, lim_oe, lim_out}, 16'h0003);
      // back inside the limits the alert holds until a read
      set_temp(16'h1000);
      chk("int hold", {15'h0000, lim_oe}, 16'h0001);
      rw(stl_pkg::ADDR_HYST, 1'b0, 16'h0000, q);
      chk("int clear", {15'h0000, lim_oe}, 16'h0000);
      $display("test interrupt done");
      // three-wire: select held low after the write frame, so the read has no falling select
      master.tied_low <= 1'b1;
      rw(stl_pkg::ADDR_HIGH, 1'b1, 16'h2400, q);
      rw(stl_pkg::ADDR_HIGH, 1'b0, 16'h0000, q);
      chk("three wire", q, 16'h2400);
      chk("three wire oe", {15'h0000, dout_oe}, 16'h0001);
      master.tied_low <= 1'b0;
      $display("test three wire done");
      // repeated temperature read with no further command
      set_temp(16'h1230);
      master.xfer({8'h54, 32'h0000_0000}, 40, rx);
      chk("repeat first", rx[31:16], 16'h1230);
      chk("repeat second", rx[15:0], 16'h1230);
      $display("test repeat read done");
      print_verdict();
   end

   // watchdog well beyond the expected run of about 54000 cycles
   initial begin
      repeat (90000) @(posedge ref_clk_i);
      err_total++;
      print_verdict();
   end
endmodule
`default_nettype wire
